/* File: hmp_device.sv */
// Decoder end of the serial host port: frame receiver, memory burst read-out,
// power-down by a clock fall while latch is low, sleep and software reset.
// Assumes the DRAM side pushes the requested words into word_data after mem_read_start.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module hmp_device
	import hmp_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
)
(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset
	hmp_link_if.device link, // Serial host port
	output logic mem_read_start, // Pulse: fetch a burst
	output logic [23:0] mem_read_addr, // Burst start address
	output logic [5:0] mem_read_words, // Burst length in words
	input wire logic word_valid, // Burst word offered
	output logic word_ready, // Room for a burst word
	input wire logic [WORD_BITS-1:0] word_data, // Burst word
	input wire logic event_in, // Event needing host attention
	output logic master_clock_enable, // Master clock running
	output logic chip_reset_hold, // Chip held in reset
	output logic units_suspended, // Functional units asleep
	output logic dram_refresh_enable, // DRAM refresh running
	output logic soft_reset_pulse, // Software reset strobe
	output logic underflow_flag // Read-out ran dry
);
	typedef enum {PW_ACTIVE, PW_DOWN} hmp_power_type;

	if (FIFO_DEPTH < 2)
	begin : g_bad_depth
		$error("hmp_device: FIFO_DEPTH must be at least 2");
	end

	logic latch_s1, latch_s2, latch_s3;
	logic clk_s1, clk_s2, clk_s3;
	logic din_s1, din_s2;
	logic clk_rise, clk_fall, latch_fall;
	hmp_power_type power_q;
	logic core_rst, eng_rst;
	logic [FRAME_BITS-1:0] frame_q;
	logic [4:0] bit_cnt_q;
	logic commit, cmd_read, cmd_soft;
	logic [7:0] frame_addr, frame_data;
	logic [23:0] addr_q;
	logic [5:0] burst_q;
	logic sleep_q;
	logic start_q, soft_q;
	logic [9:0] bits_left_q;
	logic [3:0] bit_idx_q;
	logic [WORD_BITS-1:0] out_shift_q;
	logic sdout_q, irq_q, underflow_q;
	logic reading, shift_edge, load;
	logic fifo_valid;
	logic [WORD_BITS-1:0] fifo_data, pop_word;
	logic mce_q, hold_q, susp_q, refresh_q;

	// Pin synchronisers, idle high
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			{latch_s1, latch_s2, latch_s3} <= 3'h7;
			{clk_s1, clk_s2, clk_s3} <= 3'h7;
			{din_s1, din_s2} <= 2'h3;
		end
		else
		begin
			{latch_s1, latch_s2, latch_s3} <= {link.host_latch_strobe, latch_s1, latch_s2};
			{clk_s1, clk_s2, clk_s3} <= {link.host_serial_clock, clk_s1, clk_s2};
			{din_s1, din_s2} <= {link.host_serial_data_in, din_s1};
		end
	end

	assign clk_rise = clk_s2 & ~clk_s3;
	assign clk_fall = ~clk_s2 & clk_s3;
	assign latch_fall = ~latch_s2 & latch_s3;

	// Power state; starts down until the host wakes it
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			power_q <= PW_DOWN;
		end
		else if (!latch_s2 && !din_s2)
		begin
			power_q <= PW_ACTIVE;
		end
		else if (!latch_s2 && clk_fall)
		begin
			power_q <= PW_DOWN;
		end
	end

	assign core_rst = rst | (power_q == PW_DOWN);
	assign eng_rst = core_rst | soft_q;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			mce_q <= 1'b0;
			hold_q <= 1'b1;
			susp_q <= 1'b0;
			refresh_q <= 1'b0;
		end
		else
		begin
			mce_q <= (power_q == PW_ACTIVE);
			hold_q <= (power_q == PW_DOWN);
			susp_q <= (power_q == PW_ACTIVE) & sleep_q;
			refresh_q <= (power_q == PW_ACTIVE);
		end
	end

	// Frame receiver: bits on rising clock while latch high
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			frame_q <= '0;
			bit_cnt_q <= '0;
		end
		else if (!latch_s2)
		begin
			bit_cnt_q <= '0;
		end
		else if (clk_rise && !reading && bit_cnt_q != 5'(FRAME_BITS))
		begin
			frame_q <= {frame_q[FRAME_BITS-2:0], din_s2};
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	assign commit = latch_fall & clk_s2 & din_s2 & (bit_cnt_q == 5'(FRAME_BITS));
	assign frame_addr = frame_q[15:8];
	assign frame_data = frame_q[7:0];
	assign cmd_read = commit & (frame_addr == CMD_MEM_READ);
	assign cmd_soft = commit & (frame_addr == REG_SOFTWARE_RESET);

	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			addr_q <= '0;
			burst_q <= BURST_COUNT_RESET;
			sleep_q <= 1'b0;
		end
		else if (commit)
		begin
			case (frame_addr)
				REG_ADDR_HIGH: addr_q[23:16] <= frame_data;
				REG_ADDR_MID: addr_q[15:8] <= frame_data;
				REG_ADDR_LOW: addr_q[7:0] <= frame_data;
				REG_BURST_COUNT: burst_q <= (frame_data > 8'(BURST_COUNT_MAX)) ?
					6'(BURST_COUNT_MAX) : frame_data[5:0];
				REG_SLEEP_CONTROL: sleep_q <= frame_data[SLEEP_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			start_q <= 1'b0;
			soft_q <= 1'b0;
		end
		else
		begin
			start_q <= cmd_read;
			soft_q <= cmd_soft;
		end
	end

	hmp_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst(rst),
		.flush(eng_rst),
		.in_valid(word_valid),
		.in_ready(word_ready),
		.in_data(word_data),
		.out_valid(fifo_valid),
		.out_ready(load),
		.out_data(fifo_data)
	);

	// Read-out: next bit after each falling clock, MSB first
	assign reading = (bits_left_q != '0);
	assign shift_edge = reading & latch_s2 & clk_fall;
	assign load = shift_edge & (bit_idx_q == '0);
	assign pop_word = fifo_valid ? fifo_data : '0;

	always_ff @(posedge sys_clk)
	begin
		if (eng_rst)
		begin
			bits_left_q <= '0;
			bit_idx_q <= '0;
			out_shift_q <= '0;
			sdout_q <= 1'b0;
		end
		else if (cmd_read)
		begin
			bits_left_q <= {burst_q, 4'h0};
			bit_idx_q <= '0;
		end
		else if (shift_edge)
		begin
			bits_left_q <= bits_left_q - 10'h001;
			bit_idx_q <= bit_idx_q + 4'h1;
			if (load)
			begin
				sdout_q <= pop_word[WORD_BITS-1];
				out_shift_q <= {pop_word[WORD_BITS-2:0], 1'b0};
			end
			else
			begin
				sdout_q <= out_shift_q[WORD_BITS-1];
				out_shift_q <= {out_shift_q[WORD_BITS-2:0], 1'b0};
			end
		end
	end

	// Sticky until reset, power-down or soft reset
	always_ff @(posedge sys_clk)
	begin
		if (eng_rst)
		begin
			underflow_q <= 1'b0;
		end
		else if (load && !fifo_valid)
		begin
			underflow_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= event_in;
		end
	end

	assign link.host_serial_data_out = sdout_q;
	assign link.host_interrupt_out = irq_q;
	assign mem_read_start = start_q;
	assign mem_read_addr = addr_q;
	assign mem_read_words = burst_q;
	assign master_clock_enable = mce_q;
	assign chip_reset_hold = hold_q;
	assign units_suspended = susp_q;
	assign dram_refresh_enable = refresh_q;
	assign soft_reset_pulse = soft_q;
	assign underflow_flag = underflow_q;
endmodule

/* File: hmp_fifo.sv */
// Word FIFO with valid/ready on both sides and a synchronous flush.
// Assumes push and pop sides share one clock.
`timescale 1ns/100ps
module hmp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
)
(
	input wire logic clk, // Clock
	input wire logic rst, // Synchronous reset
	input wire logic flush, // Drop all words
	input wire logic in_valid, // Word offered
	output logic in_ready, // Room available
	input wire logic [WIDTH-1:0] in_data, // Word in
	output logic out_valid, // Word available
	input wire logic out_ready, // Word taken
	output logic [WIDTH-1:0] out_data // Oldest word
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (2 ** AW) != DEPTH || WIDTH < 1)
	begin : g_bad_size
		$error("hmp_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic full_q;
	logic empty_q;
	logic push;
	logic pop;

	assign push = in_valid & ~full_q;
	assign pop = out_ready & ~empty_q;
	assign in_ready = ~full_q;
	assign out_valid = ~empty_q;
	assign out_data = mem_q[rd_q];

	always_comb
	begin
		count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end
		else
		begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			count_q <= count_d;
			full_q <= (count_d == (AW+1)'(DEPTH));
			empty_q <= (count_d == '0);
		end
	end
endmodule

/* File: hmp_host.sv */
// Host end of the serial host port: APB register slave that drives frames,
// power-down, wake and burst read-out on the link, with a divided link clock.
// Assumes software sequences address, burst count and read command frames itself.
`timescale 1ns/100ps
module hmp_host
	import hmp_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	hmp_link_if.host link // Serial host port
);
	typedef enum {ST_IDLE, ST_SHIFT, ST_LATCH, ST_PDOWN, ST_WAKE, ST_READ} hmp_state_type;

	hmp_state_type state_q;
	logic [5:0] step_q;
	logic [7:0] timer_q;
	logic [15:0] frame_q;
	logic [5:0] words_q;
	logic [15:0] rx_shift_q, rx_word_q;
	logic rx_valid_q, rx_set, rx_clear;
	logic latch_q, sclk_q, sdin_q;
	logic sdout_s1, sdout_s2, irq_s1, irq_s2;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q, rd_mux;
	logic busy, known, cmd_take, tick;
	hmp_op_type op;

	assign busy = (state_q != ST_IDLE);
	assign known = (paddr == APB_CMD) | (paddr == APB_STATUS) | (paddr == APB_RXDATA);
	assign op = hmp_op_type'(pwdata[CMD_OP_LSB +: 2]);
	assign cmd_take = psel & penable & pready_q & pwrite & (paddr == APB_CMD) & ~pslverr_q & ~busy;
	assign rx_clear = psel & penable & pready_q & ~pwrite & (paddr == APB_RXDATA);
	assign tick = (timer_q == '0);
	assign rx_set = (state_q == ST_READ) & tick & (step_q == 6'd32);

	always_comb
	begin
		rd_mux = '0;
		if (paddr == APB_STATUS)
		begin
			rd_mux[STAT_BUSY_BIT] = busy;
			rd_mux[STAT_RXVALID_BIT] = rx_valid_q;
			rd_mux[STAT_IRQ_BIT] = irq_s2;
		end
		else if (paddr == APB_RXDATA)
		begin
			rd_mux[15:0] = rx_word_q;
		end
	end

	// One wait state, then answer
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q <= 1'b1;
			pslverr_q <= ~known | (pwrite & (paddr == APB_CMD) & busy);
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			{sdout_s1, sdout_s2, irq_s1, irq_s2} <= 4'h0;
		end
		else
		begin
			{sdout_s1, sdout_s2} <= {link.host_serial_data_out, sdout_s1};
			{irq_s1, irq_s2} <= {link.host_interrupt_out, irq_s1};
		end
	end

	// Received word stays until read; a new word beats a same-cycle read
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rx_valid_q <= 1'b0;
		end
		else if (rx_set)
		begin
			rx_valid_q <= 1'b1;
		end
		else if (rx_clear)
		begin
			rx_valid_q <= 1'b0;
		end
	end

	// Link sequencer, one step per half link period
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			step_q <= '0;
			timer_q <= '0;
			frame_q <= '0;
			words_q <= '0;
			rx_shift_q <= '0;
			rx_word_q <= '0;
			latch_q <= 1'b1;
			sclk_q <= 1'b1;
			sdin_q <= 1'b1;
		end
		else if (state_q == ST_IDLE)
		begin
			if (cmd_take)
			begin
				unique case (op)
					OP_WRITE: state_q <= ST_SHIFT;
					OP_POWER_DOWN: state_q <= ST_PDOWN;
					OP_WAKE: state_q <= ST_WAKE;
					OP_READ: state_q <= ST_READ;
				endcase
				frame_q <= {pwdata[CMD_ADDR_LSB +: 8], pwdata[CMD_DATA_LSB +: 8]};
				words_q <= pwdata[CMD_DATA_LSB +: 6];
				step_q <= '0;
				timer_q <= 8'(LINK_HALF_CYCLES - 1);
			end
		end
		else if (!tick)
		begin
			timer_q <= timer_q - 8'h01;
		end
		else
		begin
			timer_q <= 8'(LINK_HALF_CYCLES - 1);
			step_q <= step_q + 6'h01;
			unique case (state_q)
				ST_SHIFT:
				begin
					sclk_q <= step_q[0];
					if (!step_q[0])
					begin
						sdin_q <= frame_q[15];
						frame_q <= {frame_q[14:0], 1'b0};
					end
					else if (step_q == 6'd31)
					begin
						// Data held through the last rise; it returns high as the latch falls
						step_q <= '0;
						state_q <= ST_LATCH;
					end
				end
				ST_LATCH:
				begin
					latch_q <= step_q[0];
					sdin_q <= 1'b1;
					if (step_q[0])
					begin
						state_q <= ST_IDLE;
					end
				end
				ST_PDOWN:
				begin
					latch_q <= (step_q == 6'd2);
					sclk_q <= (step_q != 6'd1);
					if (step_q == 6'd2)
					begin
						state_q <= ST_IDLE;
					end
				end
				ST_WAKE:
				begin
					latch_q <= (step_q == 6'd3);
					sdin_q <= (step_q != 6'd1);
					if (step_q == 6'd3)
					begin
						state_q <= ST_IDLE;
					end
				end
				ST_READ:
				begin
					if (step_q == '0 && (words_q == '0 || rx_valid_q))
					begin
						step_q <= '0;
						if (words_q == '0)
						begin
							// Latch pulse drops the rise that followed the last bit
							state_q <= ST_LATCH;
						end
					end
					else if (step_q[0])
					begin
						sclk_q <= 1'b1;
					end
					else
					begin
						if (step_q != '0)
						begin
							rx_shift_q <= {rx_shift_q[14:0], sdout_s2};
						end
						if (step_q == 6'd32)
						begin
							rx_word_q <= {rx_shift_q[14:0], sdout_s2};
							words_q <= words_q - 6'h01;
							step_q <= '0;
						end
						else
						begin
							sclk_q <= 1'b0;
						end
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign link.host_latch_strobe = latch_q;
	assign link.host_serial_clock = sclk_q;
	assign link.host_serial_data_in = sdin_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule

/* File: hmp_link_if.sv */
// Serial host port wires between the host controller and the decoder device.
// Assumes both ends sample the wires with their own system clock.
`timescale 1ns/100ps
interface hmp_link_if;
	logic host_latch_strobe;
	logic host_serial_clock;
	logic host_serial_data_in;
	logic host_serial_data_out;
	logic host_interrupt_out;
	modport host (
		output host_latch_strobe,
		output host_serial_clock,
		output host_serial_data_in,
		input host_serial_data_out,
		input host_interrupt_out
	);
	modport device (
		input host_latch_strobe,
		input host_serial_clock,
		input host_serial_data_in,
		output host_serial_data_out,
		output host_interrupt_out
	);
endinterface

/* File: hmp_link_monitor.sv */
// Concurrent checks on the serial host port wires between the two ends.
// Assumes both ends share sys_clk and the synchronous rst.
`timescale 1ns/100ps
module hmp_link_monitor
(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic host_latch_strobe, // Latch strobe
	input wire logic host_serial_clock, // Serial clock
	input wire logic host_serial_data_in, // Host data
	input wire logic host_serial_data_out, // Device data
	input wire logic host_interrupt_out // Device interrupt
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence s_pd_enter;
		!host_latch_strobe && $fell(host_serial_clock);
	endsequence
	sequence s_wake_enter;
		!host_latch_strobe && $fell(host_serial_data_in);
	endsequence
	a_idle_after_reset: assert property ($fell(rst) |-> host_latch_strobe && host_serial_clock && host_serial_data_in)
		else $error("lines not idle high after reset");
	a_clk_low_half: assert property ($fell(host_serial_clock) |-> (!host_serial_clock) [*4])
		else $error("serial clock low phase too short");
	a_clk_high_half: assert property ($rose(host_serial_clock) |-> host_serial_clock [*4])
		else $error("serial clock high phase too short");
	a_latch_low_min: assert property ($fell(host_latch_strobe) |-> (!host_latch_strobe) [*4])
		else $error("latch low pulse too short");
	a_latch_fall_idle: assert property ($fell(host_latch_strobe) |-> host_serial_clock && host_serial_data_in)
		else $error("latch fell with clock or data low");
	a_data_clk_low: assert property ($changed(host_serial_data_in) && host_latch_strobe |-> !host_serial_clock)
		else $error("data changed while serial clock high");
	a_pd_walk: assert property (s_pd_enter |->
		(!host_latch_strobe && !host_serial_clock && host_serial_data_in) [*4] ##1
		(host_latch_strobe && host_serial_clock))
		else $error("power-down sequence malformed");
	a_wake_walk: assert property (s_wake_enter |->
		(!host_latch_strobe && !host_serial_data_in && host_serial_clock) [*4] ##1
		(!host_latch_strobe && host_serial_data_in) [*4] ##1 host_latch_strobe)
		else $error("wake sequence malformed");
	a_irq_pd_quiet: assert property (s_pd_enter ##6 1'b1 |-> !host_interrupt_out)
		else $error("interrupt raised while powered down");
endmodule

/* File: hmp_pkg.sv */
// Shared constants for the serial host port: device register map, command codes,
// link timing and the host controller's own APB register map.
// Assumes both ends run from one 10 MHz system clock.
package hmp_pkg;
	// Device registers reached over the serial frames
	localparam logic [7:0] REG_SLEEP_CONTROL = 8'hDF;
	localparam logic [7:0] REG_SOFTWARE_RESET = 8'hE0;
	localparam logic [7:0] REG_ADDR_HIGH = 8'hF0;
	localparam logic [7:0] REG_ADDR_MID = 8'hF1;
	localparam logic [7:0] REG_ADDR_LOW = 8'hF2;
	localparam logic [7:0] REG_BURST_COUNT = 8'hF3;
	localparam logic [7:0] CMD_MEM_READ = 8'h50;
	localparam logic [5:0] BURST_COUNT_RESET = 6'h01;
	localparam int BURST_COUNT_MAX = 63;
	localparam int SLEEP_BIT = 7;
	localparam int WORD_BITS = 16;
	localparam int FRAME_BITS = 16;
	// Link timing
	localparam int SYS_PERIOD_NS = 100;
	localparam int LINK_PERIOD_NS = 800;
	localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;
	// Host controller APB map
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_RXDATA = 8'h08;
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_OP_LSB = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RXVALID_BIT = 1;
	localparam int STAT_IRQ_BIT = 2;
	typedef enum logic [1:0] {OP_WRITE, OP_POWER_DOWN, OP_WAKE, OP_READ} hmp_op_type;
endpackage

/* File: testbench.sv */
// Self-checking bench: APB host controller and decoder device joined by the link.
// Assumes one 10 MHz clock; the bench plays DRAM side and software.
`timescale 1ns/100ps
module testbench;
	import hmp_pkg::*;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, mem_read_start, word_valid = 0, word_ready, event_in = 0;
	logic [23:0] mem_read_addr;
	logic [5:0] mem_read_words;
	logic [15:0] word_data = 0;
	logic clk_en, rst_hold, suspended, refresh, soft_pulse, underflow;
	int miscompares = 0, n_checks = 0, n_start = 0, n_soft = 0, cycles = 0, pushed;
	hmp_link_if link_bus();
	hmp_host u_hmp_host(.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_bus));
	hmp_device #(.FIFO_DEPTH(16)) u_hmp_device(.sys_clk(sys_clk), .rst(rst), .link(link_bus),
		.mem_read_start(mem_read_start), .mem_read_addr(mem_read_addr), .mem_read_words(mem_read_words),
		.word_valid(word_valid), .word_ready(word_ready), .word_data(word_data), .event_in(event_in),
		.master_clock_enable(clk_en), .chip_reset_hold(rst_hold), .units_suspended(suspended),
		.dram_refresh_enable(refresh), .soft_reset_pulse(soft_pulse), .underflow_flag(underflow));
	hmp_link_monitor mon(.sys_clk(sys_clk), .rst(rst), .host_latch_strobe(link_bus.host_latch_strobe),
		.host_serial_clock(link_bus.host_serial_clock), .host_serial_data_in(link_bus.host_serial_data_in),
		.host_serial_data_out(link_bus.host_serial_data_out), .host_interrupt_out(link_bus.host_interrupt_out));
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		if (mem_read_start === 1'b1) n_start <= n_start + 1;
		if (soft_pulse === 1'b1) n_soft <= n_soft + 1;
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			results();
		end
	end
	task results;
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task wait_bit(input int b, input logic v);
		do apb(1'b0, APB_STATUS, 32'h0); while (rd[b] !== v);
	endtask
	task send(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, APB_CMD, {14'h0, op, a, d});
		wait_bit(STAT_BUSY_BIT, 1'b0);
		repeat (8) @(posedge sys_clk);
	endtask
	task fill(output int n);
		n = 0;
		for (int i = 0; i < 17; i++)
		begin
			word_valid <= 1;
			word_data <= 16'hA5C0 | 16'(i);
			@(posedge sys_clk);
			if (word_ready !== 1'b1) break;
			n++;
		end
		word_valid <= 0;
	endtask
	task t_wake;
		chk("hold_at_reset", 1, rst_hold);
		send(OP_WAKE, 8'h00, 8'h00);
		chk("clk_en", 1, clk_en);
		chk("hold", 0, rst_hold);
		chk("words_reset", 1, mem_read_words);
		send(OP_WRITE, REG_SOFTWARE_RESET, 8'h00);
		chk("soft_pulses", 1, n_soft);
	endtask
	task t_burst;
		send(OP_WRITE, REG_ADDR_HIGH, 8'h12);
		send(OP_WRITE, REG_ADDR_MID, 8'h34);
		send(OP_WRITE, REG_ADDR_LOW, 8'h56);
		send(OP_WRITE, REG_BURST_COUNT, 8'h02);
		chk("addr", 24'h123456, mem_read_addr);
		chk("words", 2, mem_read_words);
		chk("no_start", 0, n_start);
		send(OP_WRITE, CMD_MEM_READ, 8'h00);
		chk("start", 1, n_start);
		fill(pushed);
		chk("fifo_fill", 16, pushed);
		apb(1'b1, APB_CMD, {14'h0, OP_READ, 8'h00, 8'h02});
		for (int i = 0; i < 2; i++)
		begin
			wait_bit(STAT_RXVALID_BIT, 1'b1);
			apb(1'b0, APB_RXDATA, 32'h0);
			chk("rx_word", {16'h0, 16'hA5C0 | 16'(i)}, rd);
		end
		wait_bit(STAT_BUSY_BIT, 1'b0);
		chk("underflow", 0, underflow);
		send(OP_WRITE, REG_SOFTWARE_RESET, 8'h00);
		fill(pushed);
		chk("fifo_flushed", 16, pushed);
		send(OP_WRITE, REG_BURST_COUNT, 8'h40);
		chk("words_clamp", BURST_COUNT_MAX, mem_read_words);
	endtask
	task t_sleep;
		send(OP_WRITE, REG_SLEEP_CONTROL, 8'h80);
		chk("suspended", 1, suspended);
		chk("refresh_sleep", 1, refresh);
		chk("clk_sleep", 1, clk_en);
		send(OP_WRITE, REG_SLEEP_CONTROL, 8'h7F);
		chk("awake", 0, suspended);
	endtask
	task t_irq_pd;
		event_in <= 1;
		repeat (8) @(posedge sys_clk);
		chk("irq_pin", 1, link_bus.host_interrupt_out);
		apb(1'b0, APB_STATUS, 32'h0);
		chk("irq_status", 1, rd[STAT_IRQ_BIT]);
		send(OP_POWER_DOWN, 8'h00, 8'h00);
		chk("pd_hold", 1, rst_hold);
		chk("pd_clk", 0, clk_en);
		chk("pd_refresh", 0, refresh);
		chk("pd_irq", 0, link_bus.host_interrupt_out);
		event_in <= 0;
		apb(1'b1, 8'h0C, 32'h0);
		chk("unmapped_err", 1, err);
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		t_wake();
		t_burst();
		t_sleep();
		t_irq_pd();
		results();
	end
endmodule
